// File: rtl/wake_timer_pkg.sv
// constants, register map and state types of the wake-up timer block
package wake_timer_pkg;
   // ----------------------------------------
   // clocks and tick generation
   // ----------------------------------------
   localparam int CLK_FREQ_HZ = 25000000;
   localparam int RC_FREQ_HZ = 32768;
   localparam int NCO_WIDTH = 24;
   localparam logic [NCO_WIDTH-1:0] NCO_STEP =
      NCO_WIDTH'((longint'(RC_FREQ_HZ) << NCO_WIDTH) / longint'(CLK_FREQ_HZ));
   // ----------------------------------------
   // period arithmetic
   // ----------------------------------------
   localparam int EXP_WIDTH = 5;
   localparam int PRESCALE_WIDTH = 36;
   localparam logic [PRESCALE_WIDTH-1:0] UNIT_LEN_BASE = 36'h0_0000_0004;
   localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_ONE = 36'h0_0000_0001;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam int ADDR_WIDTH = 7;
   localparam logic [6:0] ADDR_STATUS_1 = 7'h03;
   localparam logic [6:0] ADDR_STATUS_2 = 7'h04;
   localparam logic [6:0] ADDR_INT_ENABLE_2 = 7'h06;
   localparam logic [6:0] ADDR_OP_CONTROL_1 = 7'h07;
   localparam logic [6:0] ADDR_OP_CONTROL_2 = 7'h08;
   localparam logic [6:0] ADDR_WAKE_PERIOD_EXPONENT = 7'h14;
   localparam logic [6:0] ADDR_WAKE_PERIOD_MANTISSA_HIGH = 7'h15;
   localparam logic [6:0] ADDR_WAKE_PERIOD_MANTISSA_LOW = 7'h16;
   localparam logic [6:0] ADDR_WAKE_COUNT_HIGH = 7'h17;
   localparam logic [6:0] ADDR_WAKE_COUNT_LOW = 7'h18;
   localparam logic [6:0] ADDR_LISTEN_WINDOW_TIME = 7'h19;
   localparam logic [7:0] RESET_EXPONENT = 8'h03;
   localparam logic [7:0] RESET_MANTISSA = 8'h00;
   localparam logic [7:0] RESET_OP_CONTROL_1 = 8'h01;
   localparam logic [7:0] RESET_ZERO = 8'h00;
   localparam int CTRL_READY_BIT = 0;
   localparam int CTRL_CRYSTAL_SEL_BIT = 4;
   localparam int CTRL_TIMER_EN_BIT = 5;
   localparam int CTRL_LISTEN_MODE_BIT = 2;
   localparam int INT_WAKE_BIT = 3;
   // ----------------------------------------
   // serial port and states
   // ----------------------------------------
   localparam logic [2:0] SPI_BYTE_LAST = 3'h7;
   typedef enum logic [1:0] {
      ST_READY = 2'b00,
      ST_SLEEP = 2'b01,
      ST_LISTEN = 2'b10,
      ST_EXTEND = 2'b11
   } op_state_t;
endpackage

// File: rtl/wake_tick_source.sv
// 32.768 kHz tick source: internal rc model or external crystal pin
`timescale 1ns/1ps
`default_nettype none
module wake_tick_source
   import wake_timer_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic crystal_select_in,
   input wire logic crystal_pin_in,
   output logic tick_out
);
   logic [NCO_WIDTH-1:0] phase;
   logic rc_carry;
   logic xtal_meta;
   logic xtal_sync;
   logic xtal_prev;
   logic [NCO_WIDTH:0] next_phase;

   assign next_phase = {1'b0, phase} + {1'b0, NCO_STEP};

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         phase <= '0;
         rc_carry <= 1'b0;
      end else begin
         phase <= next_phase[NCO_WIDTH-1:0];
         rc_carry <= next_phase[NCO_WIDTH];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         xtal_meta <= 1'b0;
         xtal_sync <= 1'b0;
         xtal_prev <= 1'b0;
      end else begin
         xtal_meta <= crystal_pin_in;
         xtal_sync <= xtal_meta;
         xtal_prev <= xtal_sync;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tick_out <= 1'b0;
      end else begin
         tick_out <= crystal_select_in ? (xtal_sync & ~xtal_prev) : rc_carry;
      end
   end
endmodule
`default_nettype wire

// File: rtl/wake_spi_slave.sv
// serial register port: command byte then auto-incrementing data bytes
`timescale 1ns/1ps
`default_nettype none
module wake_spi_slave
   import wake_timer_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic spi_select_n_in,
   input wire logic spi_clock_in,
   input wire logic spi_data_in,
   output logic spi_data_out,
   output logic [6:0] addr_out,
   output logic wr_pulse_out,
   output logic [7:0] wr_data_out,
   output logic rd_pulse_out,
   input wire logic [7:0] rd_data_in
);
   logic [1:0] sel_meta;
   logic [2:0] sclk_sync;
   logic [1:0] sdi_sync;
   logic [2:0] bit_cnt;
   logic [6:0] shift_in;
   logic [7:0] shift_out;
   logic first;
   logic is_write;
   logic load_pend;
   logic rise;
   logic fall;
   logic selected;

   assign selected = ~sel_meta[1];
   assign rise = sclk_sync[1] & ~sclk_sync[2];
   assign fall = ~sclk_sync[1] & sclk_sync[2];
   assign spi_data_out = shift_out[7];
   // read strobe at the end of a delivered byte, so a prefetch never clears status
   assign rd_pulse_out = selected & rise & (bit_cnt == SPI_BYTE_LAST) & ~first & ~is_write;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sel_meta <= 2'b11;
         sclk_sync <= '0;
         sdi_sync <= '0;
      end else begin
         sel_meta <= {sel_meta[0], spi_select_n_in};
         sclk_sync <= {sclk_sync[1:0], spi_clock_in};
         sdi_sync <= {sdi_sync[0], spi_data_in};
      end
   end

   // ----------------------------------------
   // receive side
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         bit_cnt <= '0;
         shift_in <= '0;
         first <= 1'b1;
         is_write <= 1'b0;
         addr_out <= '0;
         wr_pulse_out <= 1'b0;
         wr_data_out <= '0;
         load_pend <= 1'b0;
      end else begin
         wr_pulse_out <= 1'b0;
         // write strobe carries its own address, step afterwards
         if (wr_pulse_out) begin
            addr_out <= addr_out + 7'h01;
         end
         if (!selected) begin
            bit_cnt <= '0;
            first <= 1'b1;
            load_pend <= 1'b0;
         end else if (rise) begin
            shift_in <= {shift_in[5:0], sdi_sync[1]};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == SPI_BYTE_LAST) begin
               first <= 1'b0;
               if (first) begin
                  is_write <= shift_in[6];
                  addr_out <= {shift_in[5:0], sdi_sync[1]};
                  load_pend <= ~shift_in[6];
               end else begin
                  if (is_write) begin
                     wr_pulse_out <= 1'b1;
                     wr_data_out <= {shift_in, sdi_sync[1]};
                  end else begin
                     addr_out <= addr_out + 7'h01;
                  end
                  load_pend <= ~is_write;
               end
            end
         end else if (fall && load_pend) begin
            load_pend <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // transmit side
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         shift_out <= '0;
      end else if (selected && fall) begin
         if (load_pend) begin
            shift_out <= rd_data_in;
         end else begin
            shift_out <= {shift_out[6:0], 1'b0};
         end
      end
   end
endmodule
`default_nettype wire

// File: rtl/wake_timer_low_duty_cycle.sv
// wake-up timer with low duty cycle receive sequencing
`timescale 1ns/1ps
`default_nettype none
module wake_timer_low_duty_cycle
   import wake_timer_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic spi_select_n_in,
   input wire logic spi_clock_in,
   input wire logic spi_data_in,
   output logic spi_data_out,
   input wire logic first_general_pin_in,
   output logic first_general_pin_out,
   output logic first_general_pin_oe_out,
   input wire logic preamble_detect_in,
   input wire logic sync_detect_in,
   output logic interrupt_request_n_out,
   output logic host_clock_enable_out,
   output logic receiver_on_out
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [6:0] addr;
   logic wr_pulse;
   logic [7:0] wr_data;
   logic rd_pulse;
   logic [7:0] rd_data;
   logic tick;
   logic [EXP_WIDTH-1:0] wake_period_exponent;
   logic [7:0] wake_period_mantissa_high;
   logic [7:0] wake_period_mantissa_low;
   logic [7:0] op_control_1;
   logic [7:0] op_control_2;
   logic [7:0] int_enable_2;
   logic [7:0] listen_window_time;
   logic [15:0] wake_count;
   logic [15:0] mantissa;
   logic [PRESCALE_WIDTH-1:0] prescale;
   logic [PRESCALE_WIDTH-1:0] unit_len;
   logic [7:0] listen_cnt;
   logic armed;
   logic wake_flag;
   logic counting;
   logic unit_done;
   logic expiry;
   logic wake_irq_en;
   logic listen_mode;
   logic crystal_select;
   logic detect;
   logic listen_done;
   logic sleep_cmd;
   logic wake_up;
   op_state_t state;
   op_state_t next_state;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   assign mantissa = {wake_period_mantissa_high, wake_period_mantissa_low};
   assign wake_irq_en = int_enable_2[INT_WAKE_BIT];
   assign listen_mode = op_control_2[CTRL_LISTEN_MODE_BIT];
   assign crystal_select = op_control_1[CTRL_CRYSTAL_SEL_BIT];
   assign detect = preamble_detect_in & sync_detect_in;
   assign sleep_cmd = wr_pulse && addr == ADDR_OP_CONTROL_1;

   // ----------------------------------------
   // register port and tick source
   // ----------------------------------------
   wake_spi_slave i_wake_spi_slave (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .spi_select_n_in(spi_select_n_in),
      .spi_clock_in(spi_clock_in),
      .spi_data_in(spi_data_in),
      .spi_data_out(spi_data_out),
      .addr_out(addr),
      .wr_pulse_out(wr_pulse),
      .wr_data_out(wr_data),
      .rd_pulse_out(rd_pulse),
      .rd_data_in(rd_data)
   );

   wake_tick_source i_wake_tick_source (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .crystal_select_in(crystal_select),
      .crystal_pin_in(first_general_pin_in),
      .tick_out(tick)
   );

   // ----------------------------------------
   // register file
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wake_period_exponent <= RESET_EXPONENT[EXP_WIDTH-1:0];
         wake_period_mantissa_high <= RESET_MANTISSA;
         wake_period_mantissa_low <= RESET_MANTISSA;
         op_control_2 <= RESET_ZERO;
         int_enable_2 <= RESET_ZERO;
         listen_window_time <= RESET_ZERO;
      end else if (wr_pulse) begin
         unique case (addr)
            ADDR_WAKE_PERIOD_EXPONENT: wake_period_exponent <= wr_data[EXP_WIDTH-1:0];
            ADDR_WAKE_PERIOD_MANTISSA_HIGH: wake_period_mantissa_high <= wr_data;
            ADDR_WAKE_PERIOD_MANTISSA_LOW: wake_period_mantissa_low <= wr_data;
            ADDR_OP_CONTROL_2: op_control_2 <= wr_data;
            ADDR_INT_ENABLE_2: int_enable_2 <= wr_data;
            ADDR_LISTEN_WINDOW_TIME: listen_window_time <= wr_data;
            default: ;
         endcase
      end
   end

   // operating control: a wake sets the ready bit, set wins over write
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         op_control_1 <= RESET_OP_CONTROL_1;
      end else begin
         if (sleep_cmd) begin
            op_control_1 <= wr_data;
         end
         if (wake_up) begin
            op_control_1[CTRL_READY_BIT] <= 1'b1;
         end
      end
   end

   always_comb begin
      rd_data = RESET_ZERO;
      unique case (addr)
         ADDR_STATUS_2: rd_data[INT_WAKE_BIT] = wake_flag;
         ADDR_INT_ENABLE_2: rd_data = int_enable_2;
         ADDR_OP_CONTROL_1: rd_data = op_control_1;
         ADDR_OP_CONTROL_2: rd_data = op_control_2;
         ADDR_WAKE_PERIOD_EXPONENT: rd_data[EXP_WIDTH-1:0] = wake_period_exponent;
         ADDR_WAKE_PERIOD_MANTISSA_HIGH: rd_data = wake_period_mantissa_high;
         ADDR_WAKE_PERIOD_MANTISSA_LOW: rd_data = wake_period_mantissa_low;
         ADDR_WAKE_COUNT_HIGH: rd_data = wake_count[15:8];
         ADDR_WAKE_COUNT_LOW: rd_data = wake_count[7:0];
         ADDR_LISTEN_WINDOW_TIME: rd_data = listen_window_time;
         default: rd_data = RESET_ZERO;
      endcase
   end

   // ----------------------------------------
   // period counter
   // ----------------------------------------
   assign counting = armed && state != ST_READY;
   assign unit_len = UNIT_LEN_BASE << wake_period_exponent;
   assign unit_done = tick && counting && prescale == unit_len - PRESCALE_ONE;
   assign expiry = unit_done && mantissa != 16'h0000 && wake_count == mantissa - 16'h0001;

   // timer enable is caught as the device goes to sleep
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         armed <= 1'b0;
      end else if (sleep_cmd) begin
         armed <= wr_data[CTRL_TIMER_EN_BIT];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         prescale <= '0;
      end else if (sleep_cmd || !counting) begin
         prescale <= '0;
      end else if (unit_done) begin
         prescale <= '0;
      end else if (tick) begin
         prescale <= prescale + PRESCALE_ONE;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wake_count <= '0;
      end else if (sleep_cmd || !counting) begin
         wake_count <= '0;
      end else if (expiry) begin
         wake_count <= '0;
      end else if (unit_done) begin
         wake_count <= wake_count + 16'h0001;
      end
   end

   // ----------------------------------------
   // operating state sequencing
   // ----------------------------------------
   assign listen_done = unit_done && listen_cnt + 8'h01 >= listen_window_time;
   assign wake_up = expiry && wake_irq_en;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_READY: next_state = ST_READY;
         ST_SLEEP: begin
            if (wake_up) begin
               next_state = ST_READY;
            end else if (expiry && listen_mode) begin
               next_state = ST_LISTEN;
            end
         end
         ST_LISTEN: begin
            if (wake_up) begin
               next_state = ST_READY;
            end else if (detect) begin
               next_state = ST_EXTEND;
            end else if (listen_done) begin
               next_state = ST_SLEEP;
            end
         end
         ST_EXTEND: begin
            if (wake_up) begin
               next_state = ST_READY;
            end else if (listen_done) begin
               next_state = ST_SLEEP;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state <= ST_READY;
      end else if (sleep_cmd) begin
         state <= wr_data[CTRL_READY_BIT] ? ST_READY : ST_SLEEP;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         listen_cnt <= '0;
      end else if (state != next_state || state == ST_SLEEP || state == ST_READY) begin
         listen_cnt <= '0;
      end else if (unit_done) begin
         listen_cnt <= listen_cnt + 8'h01;
      end
   end

   // ----------------------------------------
   // status flag and outputs
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wake_flag <= 1'b0;
      end else if (expiry) begin
         wake_flag <= 1'b1;
      end else if (rd_pulse && addr == ADDR_STATUS_2) begin
         wake_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         interrupt_request_n_out <= 1'b1;
         host_clock_enable_out <= 1'b1;
         receiver_on_out <= 1'b0;
         first_general_pin_out <= 1'b0;
         first_general_pin_oe_out <= 1'b0;
      end else begin
         interrupt_request_n_out <= ~(wake_flag & wake_irq_en);
         host_clock_enable_out <= state == ST_READY;
         receiver_on_out <= state == ST_LISTEN || state == ST_EXTEND;
         first_general_pin_out <= ~crystal_select & wake_flag;
         first_general_pin_oe_out <= crystal_select;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   AST_COUNT_ONLY_ARMED: assert property (!counting |=> wake_count == 16'h0000)
      else $error("wake count moved while timer not armed");
   AST_IRQ_LOW: assert property (expiry && wake_irq_en |=> ##1 !interrupt_request_n_out)
      else $error("request not asserted after enabled expiry");
   AST_IRQ_HIGH_NO_EN: assert property (!wake_irq_en |=> interrupt_request_n_out)
      else $error("request asserted with wake interrupt disabled");
   AST_COUNT_READ: assert property (addr == ADDR_WAKE_COUNT_LOW |-> rd_data == wake_count[7:0])
      else $error("count low byte read wrong");
   AST_COUNT_LIMIT: assert property (counting && mantissa != 16'h0000 && $stable(mantissa)
      |-> wake_count < mantissa)
      else $error("count passed mantissa");
   AST_WAKE_READY: assert property (wake_up && !sleep_cmd |=> state == ST_READY ##1 host_clock_enable_out)
      else $error("enabled expiry did not wake device");
   AST_NO_WAKE_DISABLED: assert property (state == ST_SLEEP && expiry && !wake_irq_en && !sleep_cmd
      |=> state != ST_READY)
      else $error("state changed on disabled expiry");
   AST_PIN_RELEASED: assert property (crystal_select |=> first_general_pin_oe_out)
      else $error("first general pin driven while crystal selected");
   AST_LISTEN_START: assert property (state == ST_SLEEP && expiry && listen_mode && !wake_irq_en
      && !sleep_cmd |=> state == ST_LISTEN ##1 receiver_on_out)
      else $error("receiver not turned on at period");
   AST_LISTEN_END: assert property (state == ST_LISTEN && listen_done && !detect && !wake_up
      && !sleep_cmd |=> state == ST_SLEEP)
      else $error("listen did not return to sleep");
   AST_EXTEND: assert property (state == ST_LISTEN && detect && !wake_up && !sleep_cmd
      |=> state == ST_EXTEND && listen_cnt == 8'h00)
      else $error("detection did not extend receive");
   AST_RESTART: assert property (expiry |=> wake_count == 16'h0000 && prescale == '0)
      else $error("timer did not restart after expiry");
   AST_FLAG_SET_WINS: assert property (expiry |=> wake_flag)
      else $error("wake flag lost on expiry");
   AST_FLAG_CLEARED: assert property (rd_pulse && addr == ADDR_STATUS_2 && !expiry |=> !wake_flag)
      else $error("wake flag not cleared by status read");
   AST_PIN_FLAG: assert property (!crystal_select |=> first_general_pin_out == $past(wake_flag))
      else $error("first general pin does not show wake flag");
   AST_RX_OFF_SLEEP: assert property (state == ST_SLEEP |=> !receiver_on_out)
      else $error("receiver on while asleep");

   COV_WAKE: cover property (state == ST_SLEEP ##1 state == ST_READY);
   COV_LISTEN_MISS: cover property (state == ST_LISTEN ##1 state == ST_SLEEP);
   COV_LISTEN_HIT: cover property (state == ST_LISTEN ##1 state == ST_EXTEND);
   COV_CRYSTAL: cover property (crystal_select && expiry);
endmodule
`default_nettype wire

// File: tb/host_spi_model.sv
// host side serial master model for register access
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
   input wire logic clk_in,
   input wire logic miso_in,
   output logic sel_n_out,
   output logic sclk_out,
   output logic mosi_out
);
   initial begin
      sel_n_out = 1'b1;
      sclk_out = 1'b0;
      mosi_out = 1'b0;
   end
   // ----------------------------------------
   // byte shift, half period 8 clocks
   // ----------------------------------------
   task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi_out <= tx[i];
         repeat (7) @(posedge clk_in);
         rx[i] = miso_in;
         @(posedge clk_in);
         sclk_out <= 1'b1;
         repeat (8) @(posedge clk_in);
         sclk_out <= 1'b0;
      end
   endtask
   // ----------------------------------------
   // one frame: command byte then one data byte
   // ----------------------------------------
   task automatic access(input logic wr, input logic [6:0] addr, input logic [7:0] wd,
                         output logic [7:0] rd);
      logic [7:0] unused;
      sel_n_out <= 1'b0;
      shift({wr, addr}, unused);
      shift(wd, rd);
      repeat (8) @(posedge clk_in);
      sel_n_out <= 1'b1;
      mosi_out <= ~mosi_out;
      repeat (8) @(posedge clk_in);
   endtask
endmodule
`default_nettype wire

// File: tb/wake_timer_low_duty_cycle_bench.sv
// self-checking bench for the wake-up timer block
`timescale 1ns/1ps
`default_nettype none
module wake_timer_low_duty_cycle_bench
   import wake_timer_pkg::*;
;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic preamble = 1'b0;
   logic sync = 1'b0;
   logic xtal = 1'b0;
   logic xtal_run = 1'b0;
   logic [7:0] rd;
   wire logic sel_n, sclk, mosi, miso, pin_wire, pin_out, pin_oe, irq_n, hclk_en, rx_on;
   int n_errors = 0;
   int tests_run = 0;
   int k;
   always #20 clk_in = ~clk_in;
   always begin
      repeat (381) @(posedge clk_in);
      if (xtal_run) xtal <= ~xtal;
   end
   assign pin_wire = (pin_oe === 1'b0) ? pin_out : xtal;
   host_spi_model i_host_spi_model (.clk_in(clk_in), .miso_in(miso), .sel_n_out(sel_n),
      .sclk_out(sclk), .mosi_out(mosi));
   wake_timer_low_duty_cycle i_wake_timer_low_duty_cycle (.clk_in(clk_in), .rst_in(rst_in),
      .spi_select_n_in(sel_n), .spi_clock_in(sclk), .spi_data_in(mosi), .spi_data_out(miso),
      .first_general_pin_in(pin_wire), .first_general_pin_out(pin_out),
      .first_general_pin_oe_out(pin_oe), .preamble_detect_in(preamble), .sync_detect_in(sync),
      .interrupt_request_n_out(irq_n), .host_clock_enable_out(hclk_en), .receiver_on_out(rx_on));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      i_host_spi_model.access(1'b1, a, d, rd);
   endtask
   task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
      i_host_spi_model.access(1'b0, a, 8'h5A, rd);
      check(rd, e);
   endtask
   function automatic logic probe(input int sel);
      case (sel)
         0: return irq_n;
         1: return rx_on;
         2: return hclk_en;
         default: return pin_out;
      endcase
   endfunction
   task automatic wait_for(input int sel, input logic lvl, input int lim);
      for (k = 0; k < lim && probe(sel) !== lvl; k++) @(posedge clk_in);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #3600us;
      n_errors++;
      print_verdict;
   end
   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      check(8'(irq_n), 8'h01);
      rdchk(ADDR_WAKE_PERIOD_EXPONENT, 8'h03);
      rdchk(ADDR_WAKE_PERIOD_MANTISSA_HIGH, 8'h00);
      rdchk(ADDR_WAKE_PERIOD_MANTISSA_LOW, 8'h00);
      rdchk(ADDR_WAKE_COUNT_HIGH, 8'h00);
      wr(ADDR_WAKE_PERIOD_MANTISSA_HIGH, 8'hA5);
      wr(ADDR_WAKE_PERIOD_MANTISSA_LOW, 8'h3C);
      wr(ADDR_WAKE_COUNT_LOW, 8'hFF);
      rdchk(ADDR_WAKE_PERIOD_MANTISSA_HIGH, 8'hA5);
      rdchk(ADDR_WAKE_PERIOD_MANTISSA_LOW, 8'h3C);
      rdchk(ADDR_WAKE_COUNT_LOW, 8'h00);
      rdchk(7'h7F, 8'h00);
      // wake with interrupt enabled, period 8 ticks
      wr(ADDR_WAKE_PERIOD_EXPONENT, 8'h01);
      wr(ADDR_WAKE_PERIOD_MANTISSA_HIGH, 8'h00);
      wr(ADDR_WAKE_PERIOD_MANTISSA_LOW, 8'h01);
      wr(ADDR_INT_ENABLE_2, 8'h08);
      wr(ADDR_OP_CONTROL_1, 8'h20);
      check(8'(hclk_en), 8'h00);
      wait_for(0, 1'b0, 9000);
      check(8'(k > 5200 && k < 6400), 8'h01);
      check(8'(irq_n), 8'h00);
      repeat (2) @(posedge clk_in);
      check(8'(hclk_en), 8'h01);
      rdchk(ADDR_STATUS_1, 8'h00);
      rdchk(ADDR_STATUS_2, 8'h08);
      check(8'(irq_n), 8'h01);
      rdchk(ADDR_OP_CONTROL_1, 8'h21);
      // wake interrupt disabled: pin shows the flag, state kept
      wr(ADDR_INT_ENABLE_2, 8'h00);
      wr(ADDR_OP_CONTROL_1, 8'h20);
      wait_for(3, 1'b1, 9000);
      check(8'({pin_out, pin_oe, irq_n, hclk_en}), 8'h0A);
      rdchk(ADDR_STATUS_2, 8'h08);
      check(8'(pin_out), 8'h00);
      wait_for(3, 1'b1, 9000);
      check(8'({pin_out, hclk_en}), 8'h02);
      // low duty cycle: unit 4 ticks, listen 2 units, period 4 units
      wr(ADDR_OP_CONTROL_1, 8'h01);
      wr(ADDR_WAKE_PERIOD_EXPONENT, 8'h00);
      wr(ADDR_WAKE_PERIOD_MANTISSA_LOW, 8'h04);
      wr(ADDR_OP_CONTROL_2, 8'h04);
      wr(ADDR_LISTEN_WINDOW_TIME, 8'h02);
      wr(ADDR_OP_CONTROL_1, 8'h20);
      wait_for(1, 1'b1, 14000);
      check(8'(rx_on), 8'h01);
      wait_for(1, 1'b0, 9000);
      check(8'(k > 5200 && k < 6400), 8'h01);
      check(8'(hclk_en), 8'h00);
      wait_for(1, 1'b1, 14000);
      check(8'(rx_on), 8'h01);
      repeat (4000) @(posedge clk_in);
      preamble <= 1'b1;
      sync <= 1'b1;
      wait_for(1, 1'b0, 10000);
      check(8'(k > 2500 && k < 7000), 8'h01);
      check(8'(hclk_en), 8'h00);
      preamble <= 1'b0;
      sync <= 1'b0;
      // crystal clock on the first general pin
      wr(ADDR_OP_CONTROL_1, 8'h01);
      rdchk(ADDR_STATUS_2, 8'h08);
      wr(ADDR_OP_CONTROL_2, 8'h00);
      wr(ADDR_WAKE_PERIOD_MANTISSA_LOW, 8'h01);
      wr(ADDR_INT_ENABLE_2, 8'h08);
      wr(ADDR_OP_CONTROL_1, 8'h30);
      check(8'(pin_oe), 8'h01);
      wait_for(0, 1'b0, 6000);
      check(8'(irq_n), 8'h01);
      xtal_run <= 1'b1;
      wait_for(0, 1'b0, 5000);
      check(8'(k > 2200 && k < 3300), 8'h01);
      rdchk(ADDR_STATUS_2, 8'h08);
      xtal_run <= 1'b0;
      print_verdict;
   end
endmodule
`default_nettype wire
